// ==== rtcesc_top.sv ====
// event steering, control bits and register port of the rtc
`timescale 1ns/1ps
`default_nettype none
module rtcesc_top
    import rtcesc_pkg::*;
(
    // clock, reset, freeze
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    // bytewide register port pins
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    // pins from outside
    input wire logic i_wake_key_input_n,
    input wire logic i_main_supply,
    // timekeeping logic on this clock
    input wire logic i_osc_tick,
    input wire logic i_alarm_match,
    input wire logic i_watchdog_expire,
    // control to timekeeping logic
    output logic o_rollover_allow,
    output logic o_load_select,
    output logic o_watchdog_on,
    output logic o_watchdog_kick,
    // open-drain pins, low means pull down
    output logic o_interrupt_out_n,
    output logic o_power_on_request_n,
    output logic o_reset_out_n
);
    // address compare shared by write strobes, read mux and ram access
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    rtcesc_ram_if ram_bus ();

    rtcesc_ram u_ram (
        .i_clock(i_clock),
        .i_clk_en(i_clk_en),
        .bus(ram_bus)
    );

    // two-stage synchroniser for every pin input
    logic [RTCESC_SYNC_W-1:0] pin_raw;
    logic [RTCESC_SYNC_W-1:0] sync1_r;
    logic [RTCESC_SYNC_W-1:0] sync2_r;
    assign pin_raw = {i_main_supply, i_wake_key_input_n, i_dq, i_addr,
                      i_oe_n, i_we_n, i_cs_n};

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_r <= 18'h3FFFF;
            sync2_r <= 18'h3FFFF;
        end else if (i_clk_en) begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic cs_s;
    logic we_s;
    logic oe_s;
    logic key_s;
    logic sup_s;
    logic [4:0] addr_s;
    logic [7:0] data_s;
    assign cs_s = ~sync2_r[RTCESC_SY_CS];
    assign we_s = ~sync2_r[RTCESC_SY_WE];
    assign oe_s = ~sync2_r[RTCESC_SY_OE];
    assign key_s = sync2_r[RTCESC_SY_KEY];
    assign sup_s = sync2_r[RTCESC_SY_SUP];
    assign addr_s = sync2_r[RTCESC_SY_ADDR +: 5];
    assign data_s = sync2_r[RTCESC_SY_DATA +: 8];

    // register state
    logic we_d_r, we_d_nxt;
    logic rd_d_r, rd_d_nxt;
    logic key_d_r, key_d_nxt;
    logic tdf_r, tdf_nxt;
    logic ksf_r, ksf_nxt;
    logic wdf_r, wdf_nxt;
    logic wd_rst_irq_r, wd_rst_irq_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] ram_addr_r, ram_addr_nxt;
    logic [7:0] dq_r, dq_nxt;
    logic dq_oe_r, dq_oe_nxt;
    logic kick_r, kick_nxt;
    logic irq_n_r, irq_n_nxt;
    logic pwr_n_r, pwr_n_nxt;
    rtcesc_rst_state_t rst_st_r, rst_st_nxt;
    logic [12:0] rst_cnt_r, rst_cnt_nxt;
    logic rst_n_r, rst_n_nxt;

    logic rd_act;
    logic wr_end;
    logic rd_end;
    logic key_fall;
    logic wd_set;
    logic interrupt_request_flag;
    logic wr_flags;
    logic wr_ctrl;
    logic wr_radr;
    logic ram_acc;
    logic [7:0] flags_rd;

    // the write takes effect at the trailing edge of the strobe
    assign wr_end = we_d_r & ~(we_s & cs_s);
    assign rd_act = cs_s & oe_s & ~we_s;
    assign rd_end = rd_d_r & ~rd_act;
    assign key_fall = key_d_r & ~key_s;
    assign wr_flags = wr_end & hit(addr_s, RTCESC_OFS_FLAGS);
    assign wr_ctrl = wr_end & hit(addr_s, RTCESC_OFS_CTRL);
    assign wr_radr = wr_end & hit(addr_s, RTCESC_OFS_RAM_ADDR);
    assign ram_acc = (wr_end | rd_end) & hit(addr_s, RTCESC_OFS_RAM_DATA);
    assign wd_set = i_watchdog_expire & ctrl_r[RTCESC_CB_WDE];

    assign interrupt_request_flag = (tdf_r & ctrl_r[RTCESC_CB_TIE]) |
                  (ksf_r & ctrl_r[RTCESC_CB_KIE]) |
                  (wdf_r & (ctrl_r[RTCESC_CB_WDE] | wd_rst_irq_r));

    always_comb begin
        flags_rd = 8'h00;
        flags_rd[RTCESC_FA_INTERRUPT_REQUEST_FLAG] = interrupt_request_flag;
        flags_rd[RTCESC_FA_WDF] = wdf_r;
        flags_rd[RTCESC_FA_KSF] = ksf_r;
        flags_rd[RTCESC_FA_TDF] = tdf_r;
    end

    assign ram_bus.we = i_clk_en & wr_end & hit(addr_s, RTCESC_OFS_RAM_DATA);
    assign ram_bus.addr = ram_addr_r;
    assign ram_bus.wdata = data_s;

    // flags and control bits
    always_comb begin
        we_d_nxt = we_s & cs_s;
        rd_d_nxt = rd_act;
        key_d_nxt = key_s;
        kick_nxt = wr_end;
        tdf_nxt = tdf_r;
        ksf_nxt = ksf_r;
        wdf_nxt = wdf_r;
        wd_rst_irq_nxt = wd_rst_irq_r;
        ctrl_nxt = ctrl_r;
        ram_addr_nxt = ram_addr_r;
        // software clears are applied first so a same-cycle event wins
        if (wr_flags) begin
            tdf_nxt = tdf_r & data_s[RTCESC_FA_TDF];
            ksf_nxt = data_s[RTCESC_FA_KSF];
            wdf_nxt = wdf_r & data_s[RTCESC_FA_WDF];
            if (!data_s[RTCESC_FA_WDF]) begin
                wd_rst_irq_nxt = 1'b0;
            end
        end
        if (i_alarm_match) begin
            tdf_nxt = 1'b1;
        end
        if (key_fall && ctrl_r[RTCESC_CB_KIE]) begin
            ksf_nxt = 1'b1;
        end
        if (wd_set) begin
            wdf_nxt = 1'b1;
        end
        if (wr_ctrl) begin
            ctrl_nxt = data_s;
        end
        if (wd_set && ctrl_r[RTCESC_CB_WDS]) begin
            wd_rst_irq_nxt = 1'b1;
            ctrl_nxt[RTCESC_CB_WDE] = 1'b0;
        end
        // an address write wins over a burst step in the same cycle
        if (wr_radr) begin
            ram_addr_nxt = data_s;
        end else if (ram_acc && ctrl_r[RTCESC_CB_BME]) begin
            ram_addr_nxt = ram_addr_r + 8'h01;
        end
    end

    // read data and pin outputs
    always_comb begin
        dq_nxt = 8'h00;
        unique case (1'b1)
            hit(addr_s, RTCESC_OFS_FLAGS): dq_nxt = flags_rd;
            hit(addr_s, RTCESC_OFS_CTRL): dq_nxt = ctrl_r;
            hit(addr_s, RTCESC_OFS_RAM_ADDR): dq_nxt = ram_addr_r;
            hit(addr_s, RTCESC_OFS_RAM_DATA): dq_nxt = ram_bus.rdata;
            default: dq_nxt = 8'h00;
        endcase
        dq_oe_nxt = rd_act;
        // irq is only driven with main supply up; it follows once it returns
        irq_n_nxt = ~(interrupt_request_flag & sup_s);
        pwr_n_nxt = ~((tdf_r & ctrl_r[RTCESC_CB_TPE]) |
                      (ksf_r & ctrl_r[RTCESC_CB_KIE]));
    end

    // reset pulse timer
    always_comb begin
        rst_st_nxt = rst_st_r;
        rst_cnt_nxt = rst_cnt_r;
        unique case (rst_st_r)
            RTCESC_RST_IDLE: begin
                if (wd_set && ctrl_r[RTCESC_CB_WDS]) begin
                    rst_st_nxt = RTCESC_RST_PULSE;
                    rst_cnt_nxt = RTCESC_RST_TICKS;
                end
            end
            RTCESC_RST_PULSE: begin
                if (i_osc_tick) begin
                    if (rst_cnt_r == 13'h0001) begin
                        rst_st_nxt = RTCESC_RST_IDLE;
                        rst_cnt_nxt = 13'h0000;
                    end else begin
                        rst_cnt_nxt = rst_cnt_r - 13'h0001;
                    end
                end
            end
            default: begin
                rst_st_nxt = RTCESC_RST_IDLE;
                rst_cnt_nxt = 13'h0000;
            end
        endcase
        // the pin gets its own flop so a state decode never glitches it
        rst_n_nxt = (rst_st_nxt != RTCESC_RST_PULSE);
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            we_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            key_d_r <= 1'b1;
            kick_r <= 1'b0;
            tdf_r <= 1'b0;
            ksf_r <= 1'b0;
            wdf_r <= 1'b0;
            wd_rst_irq_r <= 1'b0;
            ctrl_r <= RTCESC_CTRL_RESET;
            ram_addr_r <= RTCESC_RAM_ADDR_RESET;
            dq_r <= 8'h00;
            dq_oe_r <= 1'b0;
            irq_n_r <= 1'b1;
            pwr_n_r <= 1'b1;
            rst_st_r <= RTCESC_RST_IDLE;
            rst_cnt_r <= 13'h0000;
            rst_n_r <= 1'b1;
        end else if (i_clk_en) begin
            we_d_r <= we_d_nxt;
            rd_d_r <= rd_d_nxt;
            key_d_r <= key_d_nxt;
            kick_r <= kick_nxt;
            tdf_r <= tdf_nxt;
            ksf_r <= ksf_nxt;
            wdf_r <= wdf_nxt;
            wd_rst_irq_r <= wd_rst_irq_nxt;
            ctrl_r <= ctrl_nxt;
            ram_addr_r <= ram_addr_nxt;
            dq_r <= dq_nxt;
            dq_oe_r <= dq_oe_nxt;
            irq_n_r <= irq_n_nxt;
            pwr_n_r <= pwr_n_nxt;
            rst_st_r <= rst_st_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            rst_n_r <= rst_n_nxt;
        end
    end

    assign o_dq = dq_r;
    assign o_dq_oe = dq_oe_r;
    assign o_rollover_allow = ctrl_r[RTCESC_CB_TE];
    assign o_load_select = ctrl_r[RTCESC_CB_CS];
    assign o_watchdog_on = ctrl_r[RTCESC_CB_WDE];
    assign o_watchdog_kick = kick_r;
    assign o_interrupt_out_n = irq_n_r;
    assign o_power_on_request_n = pwr_n_r;
    assign o_reset_out_n = rst_n_r;
endmodule
`default_nettype wire

// ==== rtcesc_pkg.sv ====
// constants and types for the rtc event steering control block
package rtcesc_pkg;
    // register offsets on the bytewide port
    localparam logic [4:0] RTCESC_OFS_FLAGS = 5'h0E;
    localparam logic [4:0] RTCESC_OFS_CTRL = 5'h0F;
    localparam logic [4:0] RTCESC_OFS_RAM_ADDR = 5'h10;
    localparam logic [4:0] RTCESC_OFS_RAM_DATA = 5'h13;
    // flags_status_a field positions
    localparam int RTCESC_FA_INTERRUPT_REQUEST_FLAG = 0;
    localparam int RTCESC_FA_WDF = 1;
    localparam int RTCESC_FA_KSF = 2;
    localparam int RTCESC_FA_TDF = 3;
    // enables_control_b field positions
    localparam int RTCESC_CB_WDS = 0;
    localparam int RTCESC_CB_WDE = 1;
    localparam int RTCESC_CB_KIE = 2;
    localparam int RTCESC_CB_TIE = 3;
    localparam int RTCESC_CB_TPE = 4;
    localparam int RTCESC_CB_BME = 5;
    localparam int RTCESC_CB_CS = 6;
    localparam int RTCESC_CB_TE = 7;
    // reset values
    localparam logic [7:0] RTCESC_CTRL_RESET = 8'h80;
    localparam logic [7:0] RTCESC_RAM_ADDR_RESET = 8'h00;
    // reset pulse timing, counted in oscillator ticks
    localparam int RTCESC_OSC_HZ = 32768;
    localparam int RTCESC_RST_MIN_MS = 40;
    localparam int RTCESC_RST_MAX_MS = 200;
    localparam int RTCESC_RST_MIN_TICKS =
        (RTCESC_RST_MIN_MS * RTCESC_OSC_HZ + 999) / 1000;
    localparam int RTCESC_RST_MAX_TICKS =
        (RTCESC_RST_MAX_MS * RTCESC_OSC_HZ) / 1000;
    localparam logic [12:0] RTCESC_RST_TICKS =
        13'((RTCESC_RST_MIN_TICKS + RTCESC_RST_MAX_TICKS) / 2);
    // synchroniser vector layout
    localparam int RTCESC_SYNC_W = 18;
    localparam int RTCESC_SY_CS = 0;
    localparam int RTCESC_SY_WE = 1;
    localparam int RTCESC_SY_OE = 2;
    localparam int RTCESC_SY_ADDR = 3;
    localparam int RTCESC_SY_DATA = 8;
    localparam int RTCESC_SY_KEY = 16;
    localparam int RTCESC_SY_SUP = 17;

    typedef enum logic [1:0] {
        RTCESC_RST_IDLE = 2'b01,
        RTCESC_RST_PULSE = 2'b10
    } rtcesc_rst_state_t;
endpackage

// ==== rtcesc_ram_if.sv ====
// link between the steering block and its user ram
`timescale 1ns/1ps
`default_nettype none
interface rtcesc_ram_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtcesc_ram.sv ====
// 256-byte extended user ram with registered read data
`timescale 1ns/1ps
`default_nettype none
module rtcesc_ram (
    // clock and freeze
    input wire logic i_clock,
    input wire logic i_clk_en,
    // access port
    rtcesc_ram_if.mem bus
);
    logic [7:0] mem_r [0:255];
    logic [7:0] rdata_r;

    // no reset on the array: contents are undefined at power-up
    always_ff @(posedge i_clock) begin
        if (i_clk_en) begin
            if (bus.we) begin
                mem_r[bus.addr] <= bus.wdata;
            end
            rdata_r <= mem_r[bus.addr];
        end
    end

    assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// ==== rtcesc_top_sva.sv ====
// port assertions for the rtc event steering block
`timescale 1ns/1ps
`default_nettype none
module rtcesc_chk
    import rtcesc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // inputs watched
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_main_supply,
    input wire logic i_osc_tick,
    input wire logic i_watchdog_expire,
    // outputs watched
    input wire logic o_dq_oe,
    input wire logic o_rollover_allow,
    input wire logic o_watchdog_on,
    input wire logic o_watchdog_kick,
    input wire logic o_interrupt_out_n,
    input wire logic o_reset_out_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    logic [12:0] tick_r;
    logic [12:0] tick_nxt;
    // ticks seen while the reset pin is pulled down
    always_comb begin
        tick_nxt = o_reset_out_n ? 13'h0000 : tick_r + 13'(i_osc_tick);
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_r <= 13'h0000;
        end else begin
            tick_r <= tick_nxt;
        end
    end
    logic [1:0] run_r;
    logic [1:0] run_nxt;
    // cycles since reset, so the three-deep look-back has real history
    always_comb begin
        run_nxt = (run_r == 2'h3) ? run_r : run_r + 2'h1;
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_r <= 2'h0;
        end else begin
            run_r <= run_nxt;
        end
    end
    sequence s_expire;
        i_watchdog_expire && o_watchdog_on && o_reset_out_n;
    endsequence
    sequence s_rst_on;
        $fell(o_reset_out_n);
    endsequence
    property p_wd_out;
        s_expire ##0 i_main_supply |->
            ##[1:3] (!o_interrupt_out_n || !o_reset_out_n);
    endproperty
    property p_rst_wde;
        s_rst_on |-> !o_watchdog_on;
    endproperty
    property p_rst_irq;
        s_rst_on ##0 i_main_supply |-> ##[0:3] !o_interrupt_out_n;
    endproperty
    property p_rst_max;
        !o_reset_out_n |-> tick_r <= 13'(RTCESC_RST_MAX_TICKS);
    endproperty
    property p_rst_min;
        $rose(o_reset_out_n) |-> tick_r >= 13'(RTCESC_RST_MIN_TICKS);
    endproperty
    property p_te;
        $changed(o_rollover_allow) |-> o_watchdog_kick;
    endproperty
    property p_kick;
        o_watchdog_kick |=> !o_watchdog_kick;
    endproperty
    property p_rd;
        (run_r == 2'h3) |->
            o_dq_oe == $past(!i_cs_n && !i_oe_n && i_we_n, 3);
    endproperty
    a_wd_out: assert property (p_wd_out)
        else $error("watchdog expiry drove no output");
    a_rst_wde: assert property (p_rst_wde)
        else $error("watchdog_on still set under reset");
    a_rst_irq: assert property (p_rst_irq)
        else $error("reset steer gave no interrupt");
    a_rst_max: assert property (p_rst_max)
        else $error("reset pulse too long");
    a_rst_min: assert property (p_rst_min)
        else $error("reset pulse too short");
    a_te: assert property (p_te)
        else $error("rollover_allow moved without a write");
    a_kick: assert property (p_kick)
        else $error("kick pulse longer than one cycle");
    a_rd: assert property (p_rd)
        else $error("read drive mismatch");
endmodule
bind rtcesc_top rtcesc_chk u_chk (.i_clock, .i_arst_n, .i_cs_n,
    .i_oe_n, .i_we_n, .i_main_supply, .i_osc_tick, .i_watchdog_expire,
    .o_dq_oe, .o_rollover_allow, .o_watchdog_on, .o_watchdog_kick,
    .o_interrupt_out_n, .o_reset_out_n);
`default_nettype wire

// ==== rtcesc_host.sv ====
// host processor model on the bytewide register port
`timescale 1ns/1ps
`default_nettype none
module rtcesc_host (
    // clock
    input wire logic i_clock,
    // bus pins
    output logic o_cs_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [4:0] o_addr,
    output logic [7:0] o_dq,
    input wire logic [7:0] i_dq
);
    initial begin
        o_cs_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_addr = 5'h00;
        o_dq = 8'h00;
    end
    // every write restarts the watchdog period; zero clears flags
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_cs_n <= 1'b0;
        o_we_n <= 1'b0;
        o_addr <= a;
        o_dq <= d;
        repeat (4) @(posedge i_clock);
        o_cs_n <= 1'b1;
        o_we_n <= 1'b1;
        // address and data must outlive the synchronised strobe
        repeat (5) @(posedge i_clock);
        o_dq <= ~d;
        o_addr <= ~a;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_cs_n <= 1'b0;
        o_oe_n <= 1'b0;
        o_addr <= a;
        repeat (6) @(posedge i_clock);
        d = i_dq;
        o_cs_n <= 1'b1;
        o_oe_n <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// ==== rtcesc_top_tb_top.sv ====
// self-checking bench for the rtc event steering block
`timescale 1ns/1ps
`default_nettype none
module rtcesc_top_tb_top
    import rtcesc_pkg::*;
;
    localparam logic [4:0] ctl = RTCESC_OFS_CTRL;
    localparam logic [4:0] flg = RTCESC_OFS_FLAGS;
    localparam logic [4:0] ra = RTCESC_OFS_RAM_ADDR;
    localparam logic [4:0] rdt = RTCESC_OFS_RAM_DATA;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, oe_n, we_n, dq_oe, te, ls, watchdog_on, kick;
    logic irq_n, pwr_n, rso_n;
    logic [4:0] addr;
    logic [7:0] dq, rdq, v;
    logic key_n = 1'b1, sup = 1'b1, tick = 1'b0, alarm = 1'b0;
    logic wexp = 1'b0;
    int num_errors = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    rtcesc_top DUT (.i_clock(clk), .i_arst_n(rst_n), .i_clk_en(1'b1),
        .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
        .i_dq(dq), .o_dq(rdq), .o_dq_oe(dq_oe),
        .i_wake_key_input_n(key_n), .i_main_supply(sup),
        .i_osc_tick(tick), .i_alarm_match(alarm),
        .i_watchdog_expire(wexp), .o_rollover_allow(te),
        .o_load_select(ls), .o_watchdog_on(watchdog_on), .o_watchdog_kick(kick),
        .o_interrupt_out_n(irq_n), .o_power_on_request_n(pwr_n),
        .o_reset_out_n(rso_n));
    rtcesc_host host (.i_clock(clk), .o_cs_n(cs_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_addr(addr), .o_dq(dq), .i_dq(rdq));
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk("register", v, e);
    endtask
    // irq, power request, reset pins after the event has settled
    task automatic pins(input logic [2:0] e);
        repeat (8) @(posedge clk);
        chk("pins", {5'h00, irq_n, pwr_n, rso_n}, {5'h00, e});
    endtask
    // one-cycle event: 0 alarm, 1 watchdog expiry, 2 wake key
    task automatic ev(input int k);
        @(posedge clk);
        alarm <= (k == 0);
        wexp <= (k == 1);
        key_n <= (k != 2);
        @(posedge clk);
        alarm <= 1'b0;
        wexp <= 1'b0;
        key_n <= 1'b1;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(ctl, RTCESC_CTRL_RESET);
        rchk(flg, 8'h00);
        rchk(5'h11, 8'h00);
        pins(3'b111);
        for (int i = 0; i < 4; i++) begin
            host.wr(ctl, {i[1:0], 6'h00});
            rchk(ctl, {i[1:0], 6'h00});
            chk("te ls", {6'h00, te, ls}, {6'h00, i[1:0]});
        end
        $display("test control bits done");
        host.wr(ctl, 8'h98);
        ev(0);
        pins(3'b001);
        rchk(flg, 8'h09);
        host.wr(ctl, 8'h88);
        pins(3'b011);
        host.wr(ctl, 8'h80);
        rchk(flg, 8'h08);
        host.wr(flg, 8'h00);
        pins(3'b111);
        $display("test alarm done");
        ev(2);
        pins(3'b111);
        rchk(flg, 8'h00);
        host.wr(ctl, 8'h84);
        ev(2);
        pins(3'b001);
        rchk(flg, 8'h05);
        host.wr(flg, 8'h00);
        pins(3'b111);
        sup <= 1'b0;
        ev(2);
        pins(3'b101);
        sup <= 1'b1;
        pins(3'b001);
        host.wr(flg, 8'h00);
        host.wr(flg, 8'h04);
        pins(3'b001);
        host.wr(flg, 8'h00);
        $display("test wake key done");
        host.wr(ctl, 8'h82);
        ev(1);
        pins(3'b011);
        rchk(flg, 8'h03);
        host.wr(flg, 8'h00);
        host.wr(ctl, 8'h83);
        ev(1);
        pins(3'b010);
        chk("watchdog on", {7'h00, watchdog_on}, 8'h00);
        for (int n = 0; n < 9000 && rso_n !== 1'b1; n++) @(posedge clk);
        pins(3'b011);
        rchk(ctl, 8'h81);
        host.wr(flg, 8'h00);
        pins(3'b111);
        $display("test watchdog done");
        host.wr(ctl, 8'hA0);
        host.wr(ra, 8'h20);
        host.wr(rdt, 8'h11);
        host.wr(rdt, 8'h22);
        rchk(ra, 8'h22);
        for (int b = 0; b < 2; b++) begin
            host.wr(ra, 8'h20);
            rchk(rdt, 8'h11);
            rchk(rdt, (b != 0) ? 8'h11 : 8'h22);
            rchk(ra, (b != 0) ? 8'h20 : 8'h22);
            host.wr(ctl, 8'h80);
        end
        $display("test burst done");
        end_of_test();
    end
endmodule
`default_nettype wire
